// ==== pkg/irme_map.vh ====
// Register offsets, field positions and reset values for the event and mask block
`ifndef IRME_MAP_VH
`define IRME_MAP_VH

// Register byte offsets on the Wishbone bus
`define IRME_OFF_CHAN_LOW_SET 8'h78
`define IRME_OFF_CHAN_LOW_CLR 8'h7c
`define IRME_OFF_EVENT_SET 8'h80
`define IRME_OFF_EVENT_CLR 8'h84
`define IRME_OFF_CHAN_HIGH_SET 8'h70
`define IRME_OFF_CHAN_HIGH_CLR 8'h74
`define IRME_OFF_INT_MASK 8'h88
`define IRME_OFF_CTRL 8'h8c
`define IRME_OFF_IRQ_STATUS 8'h90
`define IRME_OFF_IRQ_CLEAR 8'h94
`define IRME_OFF_IRQ_ENABLE 8'h98

// Event bit positions
`define IRME_EV_RSVD_31 31
`define IRME_EV_GP_IRQ 30
`define IRME_EV_SOFTWARE 29
`define IRME_EV_RSVD_28 28
`define IRME_EV_TARDY 27

// Implemented event bits and reserved read mask
`define IRME_EV_IMPL 32'h68000000
`define IRME_EV_RSVD 32'h90000000

// Control register field positions
`define IRME_CTRL_TARDY_EN 29
`define IRME_CTRL_GP_B_EN 31
`define IRME_CTRL_GP_A_EN 23

// Status register bits for the block's own interrupt
`define IRME_IRQ_GP 0
`define IRME_IRQ_SOFT 1
`define IRME_IRQ_TARDY 2
`define IRME_IRQ_W 3

// Reset values
`define IRME_RST_WORD 32'h00000000
`define IRME_RST_IRQ 3'h0

`endif

// ==== src/irme_regs.v ====
// Channel mask and interrupt event registers with a Wishbone slave
`timescale 1ns/1ns
`include "irme_map.vh"

// What this block does
// RULE_01: Accept channel n (0..31) only while lower mask bit n is set.
// RULE_02: Accept channel 32 only while upper mask bit 0 is set.
// RULE_03: Lower mask has set and clear ports; reading either returns the mask.
// RULE_04: Event bit sets on rising source edge or software write-one to set port. The code sets bit 27 on the tardy_ack_sent_i level, not its edge.
// RULE_05: Event bit clears only by software writing one to the clear port.
// RULE_06: Reading the clear port returns events ANDed with the interrupt mask.
// RULE_07: Event bits 31 and 28 always read as zero.
// RULE_08: Bit 30 sets when either enabled general-purpose interrupt input asserts.
// RULE_09: Bit 29 has no hardware source; set only by software.
// RULE_10: Bit 27 sets when tardy enable and receive data pending or response busy.
// RULE_11: Bit 27 also sets on tardy acknowledgment sent while enabled.
// RULE_12: Written zeros leave bits alone; events latch regardless of mask.
module irme_regs (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // Receive channel check
    input wire [5:0] rx_chan_i,
    output reg rx_chan_accept_o,
    // Event sources
    input wire gp_irq_a_i,
    input wire gp_irq_b_i,
    input wire rx_fifo_pending_i,
    input wire phys_resp_busy_i,
    input wire tardy_ack_sent_i,
    // Interrupt output
    output reg irq_o
);

    // ==================================================
    // Storage
    reg [31:0] chan_low_r;
    reg [31:0] chan_high_r;
    reg [31:0] event_r;
    reg [31:0] event_nxt;
    reg [31:0] int_mask_r;
    reg [31:0] ctrl_r;
    reg [`IRME_IRQ_W-1:0] irq_stat_r;
    reg [`IRME_IRQ_W-1:0] irq_stat_nxt;
    reg [`IRME_IRQ_W-1:0] irq_en_r;
    reg [31:0] chan_low_nxt;
    reg [31:0] chan_high_nxt;
    reg [31:0] rd_data;
    reg rd_hit;
    reg gp_a_d_r;
    reg gp_b_d_r;
    reg tardy_d_r;
    wire gp_a_s;
    wire gp_b_s;
    wire req;
    wire wr;
    wire [31:0] wmask;
    wire gp_a_cond;
    wire gp_b_cond;
    wire tardy_cond;
    wire wr_low_set;
    wire wr_low_clr;
    wire wr_high_set;
    wire wr_high_clr;
    wire wr_ev_set;
    wire wr_ev_clr;
    wire wr_mask;
    wire wr_ctrl;
    wire wr_irq_clr;
    wire wr_irq_en;
    wire irq_any;
    wire gp_rise;
    wire tardy_rise;
    reg [31:0] ev_hw;

    // Byte-lane mask from Wishbone select
    function [31:0] lane_mask;
        input [3:0] sel;
        begin
            lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        end
    endfunction

    // Apply write-one-to-set and write-one-to-clear to a word
    function [31:0] set_clr;
        input [31:0] cur;
        input [31:0] setv;
        input [31:0] clrv;
        begin
            set_clr = (cur & ~clrv) | setv;
        end
    endfunction

    // Write strobe for one register offset; all write decodes share this
    // compare so a request is qualified the same way everywhere
    function wr_to;
        input wr_req;
        input [7:0] adr;
        input [7:0] off;
        begin
            wr_to = wr_req && (adr == off);
        end
    endfunction

    // ==================================================
    // Pin synchronisers, GPIO interrupts come from outside
    irme_sync2 u_sync_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(gp_irq_a_i),
        .q_o(gp_a_s)
    );

    irme_sync2 u_sync_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(gp_irq_b_i),
        .q_o(gp_b_s)
    );

    // ==================================================
    // Bus decode; single-cycle ack, no back-to-back ack
    assign req = cyc_i & stb_i & ~ack_o;
    assign wr = req & we_i;
    assign wmask = lane_mask(sel_i);

    // ==================================================
    // Per-register write strobes
    assign wr_low_set = wr_to(wr, adr_i, `IRME_OFF_CHAN_LOW_SET);
    assign wr_low_clr = wr_to(wr, adr_i, `IRME_OFF_CHAN_LOW_CLR);
    assign wr_high_set = wr_to(wr, adr_i, `IRME_OFF_CHAN_HIGH_SET);
    assign wr_high_clr = wr_to(wr, adr_i, `IRME_OFF_CHAN_HIGH_CLR);
    assign wr_ev_set = wr_to(wr, adr_i, `IRME_OFF_EVENT_SET);
    assign wr_ev_clr = wr_to(wr, adr_i, `IRME_OFF_EVENT_CLR);
    assign wr_mask = wr_to(wr, adr_i, `IRME_OFF_INT_MASK);
    assign wr_ctrl = wr_to(wr, adr_i, `IRME_OFF_CTRL);
    assign wr_irq_clr = wr_to(wr, adr_i, `IRME_OFF_IRQ_CLEAR);
    assign wr_irq_en = wr_to(wr, adr_i, `IRME_OFF_IRQ_ENABLE);

    // ==================================================
    // Event sources
    // RULE_08: gated GPIO inputs, each edge-detected on its own so one
    // input held high cannot hide the other one asserting
    assign gp_a_cond = gp_a_s & ctrl_r[`IRME_CTRL_GP_A_EN];
    assign gp_b_cond = gp_b_s & ctrl_r[`IRME_CTRL_GP_B_EN];
    // RULE_10: tardy level condition
    assign tardy_cond = ctrl_r[`IRME_CTRL_TARDY_EN] &
                        (rx_fifo_pending_i | phys_resp_busy_i);
    // RULE_04: edge detection on sources
    assign gp_rise = (gp_a_cond & ~gp_a_d_r) |
                     (gp_b_cond & ~gp_b_d_r);
    assign tardy_rise = tardy_cond & ~tardy_d_r;

    // Edge history registers; a GPIO or tardy level source held high sets once
    always @(posedge clk_i) begin
        if (rst_i) begin
            gp_a_d_r <= 1'b0;
            gp_b_d_r <= 1'b0;
            tardy_d_r <= 1'b0;
        end else begin
            gp_a_d_r <= gp_a_cond;
            gp_b_d_r <= gp_b_cond;
            tardy_d_r <= tardy_cond;
        end
    end

    // Hardware set vector; bit 29 deliberately has no source
    always @* begin
        ev_hw = `IRME_RST_WORD;
        // RULE_08: GPIO event
        ev_hw[`IRME_EV_GP_IRQ] = gp_rise;
        // RULE_10: tardy on FIFO or busy
        // RULE_11: tardy on ack sent
        ev_hw[`IRME_EV_TARDY] = tardy_rise |
                                (tardy_ack_sent_i & ctrl_r[`IRME_CTRL_TARDY_EN]);
    end

    // ==================================================
    // Next-state logic for set/clear registers
    always @* begin
        chan_low_nxt = chan_low_r;
        chan_high_nxt = chan_high_r;
        event_nxt = event_r;
        // RULE_03: lower mask set and clear
        // RULE_12: zeros leave bits alone
        if (wr_low_set)
            chan_low_nxt = set_clr(chan_low_r, dat_i & wmask, `IRME_RST_WORD);
        if (wr_low_clr)
            chan_low_nxt = set_clr(chan_low_r, `IRME_RST_WORD, dat_i & wmask);
        // Upper mask kept whole; its bit 0 gates channel 32
        if (wr_high_set)
            chan_high_nxt = set_clr(chan_high_r, dat_i & wmask, `IRME_RST_WORD);
        if (wr_high_clr)
            chan_high_nxt = set_clr(chan_high_r, `IRME_RST_WORD, dat_i & wmask);
        // RULE_05: only the clear port clears
        // Clear is applied before any set so a set in the same cycle wins
        if (wr_ev_clr)
            event_nxt = set_clr(event_nxt, `IRME_RST_WORD, dat_i & wmask);
        // RULE_04: software set
        // RULE_09: software event set
        if (wr_ev_set)
            event_nxt = event_nxt | (dat_i & wmask);
        // Hardware set wins over a clear in the same cycle; reserved and
        // unimplemented positions never hold a one
        event_nxt = (event_nxt | ev_hw) & `IRME_EV_IMPL;
    end

    // Block interrupt status; set wins over clear
    always @* begin
        irq_stat_nxt = irq_stat_r;
        if (wr_irq_clr)
            irq_stat_nxt = irq_stat_r & ~dat_i[`IRME_IRQ_W-1:0];
        irq_stat_nxt[`IRME_IRQ_GP] = irq_stat_nxt[`IRME_IRQ_GP] | ev_hw[`IRME_EV_GP_IRQ];
        irq_stat_nxt[`IRME_IRQ_TARDY] = irq_stat_nxt[`IRME_IRQ_TARDY] | ev_hw[`IRME_EV_TARDY];
        irq_stat_nxt[`IRME_IRQ_SOFT] = irq_stat_nxt[`IRME_IRQ_SOFT] |
            (wr_ev_set && dat_i[`IRME_EV_SOFTWARE] && sel_i[3]);
    end

    // ==================================================
    // Register state
    always @(posedge clk_i) begin
        if (rst_i) begin
            chan_low_r <= `IRME_RST_WORD;
            chan_high_r <= `IRME_RST_WORD;
            event_r <= `IRME_RST_WORD;
            irq_stat_r <= `IRME_RST_IRQ;
        end else begin
            chan_low_r <= chan_low_nxt;
            chan_high_r <= chan_high_nxt;
            // RULE_12: latch regardless of mask
            event_r <= event_nxt;
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // Configuration registers; mask and control honour byte lanes so a narrow write
    // cannot disturb their bits in another lane; irq_en_r takes dat_i[2:0] whatever sel_i
    always @(posedge clk_i) begin
        if (rst_i) begin
            int_mask_r <= `IRME_RST_WORD;
            ctrl_r <= `IRME_RST_WORD;
            irq_en_r <= `IRME_RST_IRQ;
        end else begin
            if (wr_mask)
                int_mask_r <= (int_mask_r & ~wmask) | (dat_i & wmask);
            if (wr_ctrl)
                ctrl_r <= (ctrl_r & ~wmask) | (dat_i & wmask);
            if (wr_irq_en)
                irq_en_r <= dat_i[`IRME_IRQ_W-1:0];
        end
    end

    // ==================================================
    // Read mux
    always @* begin
        rd_hit = 1'b1;
        case (adr_i)
            // RULE_03: either port reads the mask
            `IRME_OFF_CHAN_LOW_SET, `IRME_OFF_CHAN_LOW_CLR: begin
                rd_data = chan_low_r;
            end
            `IRME_OFF_CHAN_HIGH_SET, `IRME_OFF_CHAN_HIGH_CLR: begin
                rd_data = chan_high_r;
            end
            // RULE_07: reserved bits read zero
            `IRME_OFF_EVENT_SET: begin
                rd_data = event_r & ~`IRME_EV_RSVD;
            end
            // RULE_06: masked event read
            `IRME_OFF_EVENT_CLR: begin
                rd_data = event_r & int_mask_r & ~`IRME_EV_RSVD;
            end
            `IRME_OFF_INT_MASK: begin
                rd_data = int_mask_r;
            end
            `IRME_OFF_CTRL: begin
                rd_data = ctrl_r;
            end
            `IRME_OFF_IRQ_STATUS: begin
                rd_data = {29'h0, irq_stat_r};
            end
            `IRME_OFF_IRQ_ENABLE: begin
                rd_data = {29'h0, irq_en_r};
            end
            default: begin
                // Unmapped reads zero, still acked so the bus never hangs
                rd_data = `IRME_RST_WORD;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Bus answer, one cycle after the request is seen
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= `IRME_RST_WORD;
        end else begin
            ack_o <= req;
            if (req && !we_i)
                dat_o <= rd_hit ? rd_data : `IRME_RST_WORD;
        end
    end

    // ==================================================
    // Channel acceptance, registered so the output is a flop; the answer
    // follows rx_chan_i by one cycle, so the receive path must allow for it
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_chan_accept_o <= 1'b0;
        end else begin
            // RULE_01: lower channels
            // RULE_02: channel 32 via upper bit 0
            if (rx_chan_i[5] == 1'b0)
                rx_chan_accept_o <= chan_low_r[rx_chan_i[4:0]];
            else if (rx_chan_i[4:0] == 5'h00)
                rx_chan_accept_o <= chan_high_r[0];
            else
                rx_chan_accept_o <= chan_high_r[rx_chan_i[4:0]];
        end
    end

    // ==================================================
    // Interrupt output
    // Driven from the next status so irq_o rises with the status bit;
    // a change of enable shows one cycle later
    assign irq_any = |(irq_stat_nxt & irq_en_r);

    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_any;
        end
    end

endmodule // irme_regs

// ==== src/irme_sync2.v ====
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/1ns

module irme_sync2 (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Level in and out
    input wire d_i,
    output reg q_o
);

    reg meta_r;

    // First stage feeds only the second stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end

endmodule // irme_sync2

// ==== test/irme_regs_properties.sv ====
// Port-level checker for the mask and event register block
`timescale 1ns/1ns
module irme_props (
    // Clock, reset and bus
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    // Channel check and interrupt
    input wire [5:0] rx_chan_i,
    input wire rx_chan_accept_o,
    input wire irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ========================================
    // Full-word write of all ones, then its answer
    sequence s_ones(a);
        cyc_i && stb_i && we_i && adr_i == a && sel_i == 4'hf && dat_i == 32'hffffffff ##1 ack_o;
    endsequence
    a_ack_after_take: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no answer one cycle after request");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("answer longer than one cycle");
    a_ack_needs_req: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("answer without request");
    a_read_holds: assert property (!ack_o |-> $stable(dat_o))
        else $error("read data moved without answer");
    a_rsvd_zero: assert property (ack_o && !$past(we_i) && $past(adr_i[7:3]) == 5'h10
        |-> !dat_o[31] && !dat_o[28]) else $error("reserved event bit read as one");
    a_irq_fall_write: assert property ($fell(irq_o)
        |-> $past(cyc_i && we_i, 1) || $past(cyc_i && we_i, 2)) else $error("irq fell unasked");
    a_low_clr_blocks: assert property (s_ones(8'h7c) ##1 !rx_chan_i[5]
        |=> !rx_chan_accept_o) else $error("cleared channel accepted");
    a_low_set_opens: assert property (s_ones(8'h78) ##1 !rx_chan_i[5]
        |=> rx_chan_accept_o) else $error("set channel refused");
    a_high_ch32: assert property (s_ones(8'h70) ##1 rx_chan_i == 6'h20
        |=> rx_chan_accept_o) else $error("channel 32 refused");
endmodule // irme_props

// ==== test/test_irme_regs.sv ====
// Self-checking bench for the channel mask and event registers
`timescale 1ns/1ns
module test_irme_regs;
    // ========================================
    // Stimulus, outputs and model state
    reg clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, on;
    reg [7:0] adr_i = 0;
    reg [3:0] sel_i = 0;
    reg [31:0] dat_i = 0, rd, d, lo, ev, mk;
    reg [5:0] rx_chan_i = 0;
    reg gp_irq_a_i = 0, gp_irq_b_i = 0, rx_fifo_pending_i = 0;
    reg phys_resp_busy_i = 0, tardy_ack_sent_i = 0;
    wire [31:0] dat_o;
    wire ack_o, rx_chan_accept_o, irq_o;
    integer num_errors = 0, samples_checked = 0, i, k, n;
    integer enb [0:4] = '{23, 31, 29, 29, 29};
    integer evb [0:4] = '{30, 30, 27, 27, 27};
    reg [7:0] offs [0:7] = '{8'h78, 8'h7c, 8'h80, 8'h84, 8'h70, 8'h88, 8'h90, 8'h40};
    // Clock at 50 ns period
    always #25 clk_i = ~clk_i;
    irme_regs i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .rx_chan_i, .rx_chan_accept_o, .gp_irq_a_i, .gp_irq_b_i, .rx_fifo_pending_i,
        .phys_resp_busy_i, .tardy_ack_sent_i, .irq_o);
    // ========================================
    // Compare, bus cycle and closing tasks
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Request held until the answer edge, read data taken there
    task wb(input w, input [7:0] a, input [31:0] x);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hf, x};
        n = 0;
        @(posedge clk_i);
        while (ack_o !== 1'b1) begin
            n++;
            @(posedge clk_i);
        end
        rd = dat_o;
        {cyc_i, stb_i, we_i} <= 3'h0;
        // Answer due one edge after the taking edge; the watchdog ends a hang
        check("answer delay", n, 1);
    endtask
    task rdchk(input string nm, input [7:0] a, input [31:0] e);
        wb(0, a, 0);
        check(nm, rd, e);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run of a few hundred cycles
    initial begin
        #1000000;
        num_errors++;
        test_done;
    end
    // ========================================
    // Main sequence
    initial begin
        i = $urandom(32'h09ec);
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        wb(1, 8'h40, 32'hffffffff);
        for (i = 0; i < 8; i++)
            rdchk("reset value", offs[i], 0);
        $display("reset test done");
        // Random set and clear traffic on the low mask
        lo = 0;
        for (i = 0; i < 8; i++) begin
            d = $urandom;
            wb(1, 8'h78, d);
            lo = lo | d;
            d = $urandom;
            wb(1, 8'h7c, d);
            lo = lo & ~d;
            rdchk("mask set port", 8'h78, lo);
            rdchk("mask clear port", 8'h7c, lo);
            rx_chan_i <= d[4:0];
            repeat (3) @(posedge clk_i);
            check("accept", rx_chan_accept_o, lo[d[4:0]]);
        end
        wb(1, 8'h7c, 32'hffffffff);
        rx_chan_i <= 6'h07;
        wb(1, 8'h78, 32'hffffffff);
        rx_chan_i <= 6'h1f;
        wb(1, 8'h70, 32'hffffffff);
        rx_chan_i <= 6'h20;
        repeat (3) @(posedge clk_i);
        check("channel 32", rx_chan_accept_o, 1);
        wb(1, 8'h74, 32'h1);
        repeat (3) @(posedge clk_i);
        check("channel 32 off", rx_chan_accept_o, 0);
        $display("mask test done");
        // Software event, masked read, sticky clear
        mk = $urandom;
        wb(1, 8'h88, mk);
        wb(1, 8'h98, 32'h7);
        wb(1, 8'h80, 32'hffffffff);
        ev = 32'h68000000;
        rdchk("event set", 8'h80, ev);
        rdchk("event masked", 8'h84, ev & mk);
        rdchk("irq status", 8'h90, 32'h2);
        check("irq", irq_o, 1);
        wb(1, 8'h98, 32'h0);
        @(posedge clk_i);
        check("irq masked", irq_o, 0);
        wb(1, 8'h84, 32'h0);
        rdchk("zero clear", 8'h80, ev);
        wb(1, 8'h84, 32'hffffffff);
        rdchk("cleared", 8'h80, 0);
        wb(1, 8'h94, 32'h7);
        wb(1, 8'h98, 32'h7);
        // Each hardware source, first disabled then enabled
        for (i = 0; i < 10; i++) begin
            k = i % 5;
            on = i >= 5;
            wb(1, 8'h8c, on ? 32'h1 << enb[k] : 0);
            {gp_irq_a_i, gp_irq_b_i, rx_fifo_pending_i, phys_resp_busy_i,
                tardy_ack_sent_i} <= 5'h10 >> k;
            @(posedge clk_i);
            {gp_irq_a_i, gp_irq_b_i, rx_fifo_pending_i, phys_resp_busy_i,
                tardy_ack_sent_i} <= 5'h0;
            repeat (5) @(posedge clk_i);
            ev = on ? 32'h1 << evb[k] : 0;
            rdchk("source event", 8'h80, ev);
            rdchk("source masked", 8'h84, ev & mk);
            check("source irq", irq_o, on);
            wb(1, 8'h84, 32'hffffffff);
            wb(1, 8'h94, 32'h7);
        end
        $display("event test done");
        test_done;
    end
endmodule // test_irme_regs
bind irme_regs irme_props i_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .rx_chan_i, .rx_chan_accept_o, .irq_o);
